/* File: src/uml_pkg.sv */
package uml_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_FEAT_W  = 8'h00;  // enhanced_feature_reg
  localparam logic [7:0] ADDR_MODEM_W = 8'h04;  // modem_control_reg
  localparam logic [7:0] ADDR_EVSEL_W = 8'h08;  // interrupt_enable_reg
  localparam logic [7:0] ADDR_XFEAT_W = 8'h0C;  // extended_feature_reg
  localparam logic [7:0] ADDR_MSR    = 8'h10;  // line status
  localparam logic [7:0] ADDR_IST    = 8'h14;  // sticky events
  localparam logic [7:0] ADDR_ICLR   = 8'h18;  // event clear, write only
  localparam logic [7:0] ADDR_IEN    = 8'h1C;  // event enable
  // field positions
  localparam int FEAT_AUTO_RTS  = 6;
  localparam int FEAT_AUTO_CTS  = 7;
  localparam int MODEM_DTR      = 0;
  localparam int MODEM_RTS      = 1;
  localparam int MODEM_IR       = 6;
  localparam int EVSEL_RX_ACT   = 6;
  localparam int EVSEL_CTS_CHG  = 7;
  localparam int XFEAT_485_EN   = 2;
  localparam int XFEAT_485_POL  = 5;
  localparam int MSR_CTS       = 0;
  localparam int MSR_RXD       = 1;
  localparam int MSR_IR        = 2;
  localparam int MSR_TX_HALT   = 3;
  localparam int MSR_AUTO_RTS  = 4;
  // event bits
  localparam int EV_CTS_CHG    = 0;
  localparam int EV_HALT       = 1;
  localparam int EV_RX_ACTIVE  = 2;
  localparam int EV_W          = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  // counter start; reaches STRAP_LOAD two edges after reset release, once the strap synchroniser is settled
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] STRAP_LOAD = 2'h1;
  localparam logic [1:0] STRAP_DONE = 2'h0;
  localparam logic [1:0] STRAP_STEP = 2'h1;
endpackage : uml_pkg

/* File: src/uml_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser; first stage feeds only the second
module uml_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      q      <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : uml_sync
`default_nettype wire

/* File: src/uml_line_ctrl.sv */
// Functional notes
// - rx idles high in normal mode and low in infrared mode.
// - in infrared mode rx passes through the infrared decoder before the receiver.
// - the rts output serves auto flow control or rs485 direction control.
// - extended feature bit 2 selects rs485 direction control on rts; bit 5 sets its polarity.
// - auto rts runs only after rts was first asserted through modem control bit 1.
// - with enhanced feature bit 7 set, transmit halts while cts is deasserted.
// - under auto cts, transmit resumes once cts is asserted again.
// - without auto flow control, cts is readable by software as an input.
// - dtr is an active-low output that software drives as a general output.
// - tx idles high normally and low with active-high pulses in infrared mode.
// - the infrared start input is taken at reset release, then software bit 6 rules.
`timescale 1ns/100ps
`default_nettype none
module uml_line_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        infrared_start_select,
  input  wire logic        rx_pin,
  output logic             rx_data,
  input  wire logic        ir_rx_decoded,
  output logic             ir_rx_raw,
  input  wire logic        tx_serial,
  input  wire logic        ir_tx_pulse,
  output logic             tx_pin,
  input  wire logic        tx_busy,
  input  wire logic        tx_data_avail,
  output logic             tx_go,
  input  wire logic        rx_above_trigger,
  input  wire logic        cts_n_pin,
  output logic             rts_n_pin,
  output logic             dtr_n_pin,
  output logic             ir_mode
);
  // control registers
  logic [7:0]               feat_r;
  logic [7:0]               feat_nxt;
  logic [7:0]               modem_r;
  logic [7:0]               modem_nxt;
  logic [7:0]               evsel_r;
  logic [7:0]               evsel_nxt;
  logic [7:0]               xfeat_r;
  logic [7:0]               xfeat_nxt;
  logic [uml_pkg::EV_W-1:0] ien_r;
  logic [uml_pkg::EV_W-1:0] ien_nxt;
  logic [1:0]               strap_wait_r;
  logic [1:0]               strap_wait_nxt;
  // flow control state
  logic                     rts_armed_r;
  logic                     rts_armed_nxt;
  logic                     halted_r;
  logic                     halted_nxt;
  logic                     rts_n_r;
  logic                     rts_n_nxt;
  logic                     dtr_n_r;
  logic                     dtr_n_nxt;
  logic                     tx_r;
  logic                     tx_nxt;
  // event state
  logic [uml_pkg::EV_W-1:0] ist_r;
  logic [uml_pkg::EV_W-1:0] ist_nxt;
  logic                     cts_prev_r;
  logic                     cts_prev_nxt;
  logic [uml_pkg::EV_W-1:0] ev;
  logic [uml_pkg::EV_W-1:0] clr;
  // read path
  logic [31:0]              prdata_nxt;
  // synchronised pins and decodes
  logic                     cts_n_s;
  logic                     rx_s;
  logic                     strap_s;
  logic                     wr;
  logic                     rd;
  logic                     auto_cts;
  logic                     auto_rts;
  logic                     rs485;

  // pins from outside the clock domain
  uml_sync #(
    .RESET_VAL(1'b1)
  ) u_cts (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (cts_n_pin),
    .q     (cts_n_s)
  );
  uml_sync #(
    .RESET_VAL(1'b1)
  ) u_rx (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (rx_pin),
    .q     (rx_s)
  );
  // strap stage resets low, so its value is only trusted after two edges
  uml_sync #(
    .RESET_VAL(1'b0)
  ) u_ir (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (infrared_start_select),
    .q     (strap_s)
  );

  function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic hit);
    wr_byte = hit ? pwdata[7:0] : cur;
  endfunction : wr_byte

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr && (paddr == a);
  endfunction : wr_hit

  assign wr       = psel && penable && pwrite;
  assign rd       = psel && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign ir_mode  = modem_r[uml_pkg::MODEM_IR];
  assign auto_cts = feat_r[uml_pkg::FEAT_AUTO_CTS];
  assign auto_rts = feat_r[uml_pkg::FEAT_AUTO_RTS];
  assign rs485    = xfeat_r[uml_pkg::XFEAT_485_EN];
  // infrared: raw pulses to the decoder, decoded stream to the receiver
  assign ir_rx_raw = ir_mode ? rx_s : 1'b0;
  // receiver sees idle-high in both modes; ir idle low is decoded to high
  assign rx_data   = ir_mode ? ir_rx_decoded : rx_s;
  assign tx_go     = tx_data_avail && !(auto_cts && halted_r);
  assign rts_n_pin = rts_n_r;
  assign dtr_n_pin = dtr_n_r;
  assign tx_pin    = tx_r;
  assign irq       = |(ist_r & ien_r);

  // register group
  always_comb begin
    feat_nxt  = wr_byte(feat_r, wr_hit(uml_pkg::ADDR_FEAT_W));
    modem_nxt = wr_byte(modem_r, wr_hit(uml_pkg::ADDR_MODEM_W));
    evsel_nxt = wr_byte(evsel_r, wr_hit(uml_pkg::ADDR_EVSEL_W));
    xfeat_nxt = wr_byte(xfeat_r, wr_hit(uml_pkg::ADDR_XFEAT_W));
    ien_nxt   = wr_hit(uml_pkg::ADDR_IEN) ? pwdata[uml_pkg::EV_W-1:0] : ien_r;
    strap_wait_nxt = strap_wait_r;
    if (strap_wait_r != uml_pkg::STRAP_DONE) begin
      strap_wait_nxt = strap_wait_r - uml_pkg::STRAP_STEP;
    end
    // strap taken once the synchroniser shows the pin, not its reset value
    if (strap_wait_r == uml_pkg::STRAP_LOAD) begin
      modem_nxt[uml_pkg::MODEM_IR] = strap_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_r       <= uml_pkg::REG_RESET;
      modem_r      <= uml_pkg::REG_RESET;
      evsel_r      <= uml_pkg::REG_RESET;
      xfeat_r      <= uml_pkg::REG_RESET;
      ien_r        <= '0;
      strap_wait_r <= uml_pkg::STRAP_WAIT;
    end else begin
      feat_r       <= feat_nxt;
      modem_r      <= modem_nxt;
      evsel_r      <= evsel_nxt;
      xfeat_r      <= xfeat_nxt;
      ien_r        <= ien_nxt;
      strap_wait_r <= strap_wait_nxt;
    end
  end

  // flow control group
  always_comb begin
    // auto rts only arms after software has asserted rts once
    rts_armed_nxt = rts_armed_r | modem_r[uml_pkg::MODEM_RTS];
    if (!auto_rts) begin
      rts_armed_nxt = 1'b0;
    end
    // halt only between characters, so a shifting one finishes
    halted_nxt = halted_r;
    if (cts_n_s && !tx_busy) begin
      halted_nxt = 1'b1;
    end else if (!cts_n_s) begin
      halted_nxt = 1'b0;
    end
    // rts source select
    if (rs485) begin
      rts_n_nxt = xfeat_r[uml_pkg::XFEAT_485_POL] ? !tx_busy : tx_busy;
    end else if (auto_rts && rts_armed_r) begin
      rts_n_nxt = rx_above_trigger;
    end else begin
      rts_n_nxt = !modem_r[uml_pkg::MODEM_RTS];
    end
    dtr_n_nxt = !modem_r[uml_pkg::MODEM_DTR];
    // ir idles low with high pulses, normal idles high
    tx_nxt = ir_mode ? ir_tx_pulse : tx_serial;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_armed_r  <= 1'b0;
      halted_r     <= 1'b0;
      rts_n_r      <= 1'b1;
      dtr_n_r      <= 1'b1;
      tx_r         <= 1'b1;
    end else begin
      rts_armed_r  <= rts_armed_nxt;
      halted_r     <= halted_nxt;
      rts_n_r      <= rts_n_nxt;
      dtr_n_r      <= dtr_n_nxt;
      tx_r         <= tx_nxt;
    end
  end

  // event group
  always_comb begin
    cts_prev_nxt = cts_n_s;
    ev = '0;
    ev[uml_pkg::EV_CTS_CHG]   = (cts_prev_r != cts_n_s) && evsel_r[uml_pkg::EVSEL_CTS_CHG];
    ev[uml_pkg::EV_HALT]      = !halted_r && halted_nxt && auto_cts;
    ev[uml_pkg::EV_RX_ACTIVE] = (rx_data == 1'b0) && evsel_r[uml_pkg::EVSEL_RX_ACT];
    clr = wr_hit(uml_pkg::ADDR_ICLR) ? pwdata[uml_pkg::EV_W-1:0] : '0;
    // set wins over clear, so an event in the clear cycle is not lost
    ist_nxt = (ist_r & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r        <= '0;
      cts_prev_r   <= 1'b1;
    end else begin
      ist_r        <= ist_nxt;
      cts_prev_r   <= cts_prev_nxt;
    end
  end

  // read group: setup-phase read registers data for the access phase
  always_comb begin
    prdata_nxt = '0;
    if (rd) begin
      case (paddr)
        uml_pkg::ADDR_FEAT_W:  prdata_nxt[7:0] = feat_r;
        uml_pkg::ADDR_MODEM_W: prdata_nxt[7:0] = modem_r;
        uml_pkg::ADDR_EVSEL_W: prdata_nxt[7:0] = evsel_r;
        uml_pkg::ADDR_XFEAT_W: prdata_nxt[7:0] = xfeat_r;
        uml_pkg::ADDR_MSR: begin
          prdata_nxt[uml_pkg::MSR_CTS]      = !cts_n_s;
          prdata_nxt[uml_pkg::MSR_RXD]      = rx_s;
          prdata_nxt[uml_pkg::MSR_IR]       = ir_mode;
          prdata_nxt[uml_pkg::MSR_TX_HALT]  = auto_cts && halted_r;
          prdata_nxt[uml_pkg::MSR_AUTO_RTS] = rts_armed_r;
        end
        uml_pkg::ADDR_IST:   prdata_nxt[uml_pkg::EV_W-1:0] = ist_r;
        uml_pkg::ADDR_IEN:   prdata_nxt[uml_pkg::EV_W-1:0] = ien_r;
        default:             prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= '0;
    end else begin
      prdata       <= prdata_nxt;
    end
  end

  dtr_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 dtr_n_pin == !$past(modem_r[uml_pkg::MODEM_DTR]))
    else $error("dtr does not follow control bit");
  rts_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!rs485 && !auto_rts) |=> rts_n_pin == !$past(modem_r[uml_pkg::MODEM_RTS]))
    else $error("rts does not follow control bit");
  strap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_wait_r == uml_pkg::STRAP_LOAD) |=> ir_mode == $past(strap_s))
    else $error("infrared strap not loaded");
  ev_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev != '0) |=> (ist_r & $past(ev)) == $past(ev))
    else $error("event lost from status");
  cts_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_cts && halted_r) |-> !tx_go)
    else $error("transmit started while halted");
  cts_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_cts && !cts_n_s && tx_data_avail) |=> (tx_go || !tx_data_avail))
    else $error("transmit did not resume");
  halt_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(halted_r) |-> !$past(tx_busy))
    else $error("halt cut a character");
  rs485_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rs485 && $past(rs485) && !xfeat_r[uml_pkg::XFEAT_485_POL]
      && $past(!xfeat_r[uml_pkg::XFEAT_485_POL]))
    |-> rts_n_pin == $past(tx_busy))
    else $error("rs485 direction wrong");
  rts_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rts_armed_r) |-> $past(modem_r[uml_pkg::MODEM_RTS]))
    else $error("auto rts armed without rts");
  tx_ir_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 tx_pin == ($past(ir_mode) ? $past(ir_tx_pulse) : $past(tx_serial)))
    else $error("tx source wrong");
  rx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ir_mode |-> rx_data == ir_rx_decoded) and (!ir_mode |-> ir_rx_raw == 1'b0))
    else $error("rx routing wrong");
endmodule : uml_line_ctrl
`default_nettype wire

/* File: verification/uml_remote.sv */
`timescale 1ns/100ps
`default_nettype none
// far-side station: drives rx and cts, answers prompt or one cycle late
module uml_remote (
  input  wire logic pclk,
  input  wire logic ir,
  input  wire logic send,
  input  wire logic bit_v,
  input  wire logic cts_on,
  input  wire logic slow,
  output logic      rx_pin,
  output logic      cts_n_pin
);
  logic cts_d_r;
  always_ff @(posedge pclk) begin
    cts_d_r <= !cts_on;
  end
  assign cts_n_pin = slow ? cts_d_r : !cts_on;
  // idle level follows the mode, so the receiver never sees a false break
  assign rx_pin = send ? bit_v : !ir;
endmodule : uml_remote
`default_nettype wire

/* File: verification/test_uml_line_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module test_uml_line_ctrl;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, strap = 0, rx_pin, rx_data, ir_dec = 1, ir_raw;
  logic        tx_ser = 1, ir_pulse = 0, tx_pin, busy = 0, tx_go, above = 0, cts_n;
  logic        rts_n, dtr_n, ir_mode, send = 0, bit_v = 1, cts_on = 1, slow = 0, pin_req = 0;
  int          failures = 0, compares = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  wire logic [7:0] pins = {tx_go, ir_raw, rx_data, tx_pin, dtr_n, rts_n, irq, ir_mode};
  uml_line_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .infrared_start_select(strap), .rx_pin(rx_pin),
    .rx_data(rx_data), .ir_rx_decoded(ir_dec), .ir_rx_raw(ir_raw), .tx_serial(tx_ser),
    .ir_tx_pulse(ir_pulse), .tx_pin(tx_pin), .tx_busy(busy), .tx_data_avail(1'b1),
    .tx_go(tx_go), .rx_above_trigger(above), .cts_n_pin(cts_n), .rts_n_pin(rts_n),
    .dtr_n_pin(dtr_n), .ir_mode(ir_mode));
  uml_remote far (.pclk(pclk), .ir(ir_mode), .send(send), .bit_v(bit_v), .cts_on(cts_on),
    .slow(slow), .rx_pin(rx_pin), .cts_n_pin(cts_n));
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
    e = exp_q.pop_front();
    `CHK(prdata[7:0] & e[15:8], e[7:0])
  end
  always @(negedge pclk) if (pin_req) begin
    pin_req <= 1'b0;
    e = exp_q.pop_front();
    `CHK(pins & e[15:8], e[7:0])
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    exp_q.push_back({m, v});
    apb(1'b0, a, 8'h00);
  endtask : rd
  task automatic chk(input logic [7:0] m, input logic [7:0] v);
    exp_q.push_back({m, v});
    pin_req <= 1'b1;
    @(posedge pclk);
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic final_report;
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    final_report();
  end
  initial begin
    logic [1:0] i;
    void'($urandom(32'hAD0C));
    cyc(8);
    presetn <= 1'b1;
    cyc(3);
    chk(8'h7F, 8'h3C);
    rd(uml_pkg::ADDR_MSR, 8'h1F, 8'h03);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      i = 2'(k);
      tx_ser <= 1'($urandom);
      apb(1'b1, uml_pkg::ADDR_MODEM_W, {6'h00, i});
      cyc(2);
      chk(8'h1C, {3'h0, tx_ser, ~i[0], ~i[1], 2'h0});
    end
    tx_ser <= 1'b1;
    $display("gpio test done");
    cts_on <= 1'b0;
    send <= 1'b1;
    bit_v <= 1'b0;
    cyc(4);
    rd(uml_pkg::ADDR_MSR, 8'h03, 8'h00);
    chk(8'h20, 8'h00);
    slow <= 1'b1;
    cts_on <= 1'b1;
    send <= 1'b0;
    cyc(5);
    rd(uml_pkg::ADDR_MSR, 8'h03, 8'h03);
    $display("cts input test done");
    apb(1'b1, uml_pkg::ADDR_FEAT_W, 8'h80);
    busy <= 1'b1;
    cts_on <= 1'b0;
    cyc(5);
    rd(uml_pkg::ADDR_MSR, 8'h08, 8'h00);
    busy <= 1'b0;
    cyc(3);
    chk(8'h80, 8'h00);
    rd(uml_pkg::ADDR_MSR, 8'h08, 8'h08);
    cts_on <= 1'b1;
    cyc(5);
    chk(8'h80, 8'h80);
    apb(1'b1, uml_pkg::ADDR_FEAT_W, 8'h00);
    $display("auto cts test done");
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h00);
    apb(1'b1, uml_pkg::ADDR_FEAT_W, 8'h40);
    cyc(2);
    chk(8'h04, 8'h04);
    rd(uml_pkg::ADDR_MSR, 8'h10, 8'h00);
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h02);
    cyc(3);
    chk(8'h04, 8'h00);
    above <= 1'b1;
    cyc(3);
    chk(8'h04, 8'h04);
    rd(uml_pkg::ADDR_MSR, 8'h10, 8'h10);
    above <= 1'b0;
    apb(1'b1, uml_pkg::ADDR_FEAT_W, 8'h00);
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h00);
    $display("auto rts test done");
    for (int k = 0; k < 4; k++) begin
      i = 2'(k);
      busy <= i[0];
      apb(1'b1, uml_pkg::ADDR_XFEAT_W, {2'h0, i[1], 5'h04});
      cyc(3);
      chk(8'h04, {5'h00, i[0] ^ i[1], 2'h0});
    end
    busy <= 1'b0;
    apb(1'b1, uml_pkg::ADDR_XFEAT_W, 8'h00);
    $display("rs485 test done");
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h40);
    ir_pulse <= 1'b1;
    cyc(3);
    chk(8'h71, 8'h31);
    ir_pulse <= 1'b0;
    send <= 1'b1;
    bit_v <= 1'b1;
    ir_dec <= 1'b0;
    cyc(3);
    chk(8'h71, 8'h41);
    send <= 1'b0;
    ir_dec <= 1'b1;
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h00);
    $display("infrared test done");
    apb(1'b1, uml_pkg::ADDR_EVSEL_W, 8'h80);
    apb(1'b1, uml_pkg::ADDR_ICLR, 8'h07);
    apb(1'b1, uml_pkg::ADDR_IEN, 8'h01);
    cts_on <= 1'b0;
    cyc(5);
    chk(8'h02, 8'h02);
    rd(uml_pkg::ADDR_IST, 8'h01, 8'h01);
    apb(1'b1, uml_pkg::ADDR_ICLR, 8'h01);
    chk(8'h02, 8'h00);
    apb(1'b1, uml_pkg::ADDR_IEN, 8'h00);
    cts_on <= 1'b1;
    cyc(5);
    chk(8'h02, 8'h00);
    rd(uml_pkg::ADDR_IST, 8'h01, 8'h01);
    rd(8'h20, 8'hFF, 8'h00);
    $display("interrupt test done");
    strap <= 1'b1;
    cyc(3);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(4);
    chk(8'h1D, 8'h0D);
    apb(1'b1, uml_pkg::ADDR_MODEM_W, 8'h00);
    cyc(2);
    chk(8'h11, 8'h10);
    $display("strap test done");
    final_report();
  end
endmodule : test_uml_line_ctrl
`default_nettype wire
